/* File: pkg/rtcaux_pkg.sv */
// constants, register layout and types of the rtc auxiliary control block
package rtcaux_pkg;
    // register indices; each bus byte address is four times its index
    localparam logic [5:0] IDX_YEARS = 6'h03;
    localparam logic [5:0] IDX_RECSEL = 6'h04;
    localparam logic [5:0] IDX_CTRL = 6'h08;
    localparam logic [5:0] IDX_FLAGS = 6'h0f;
    // register byte addresses on the axi4-lite bus
    localparam logic [7:0] ADDR_YEARS = {IDX_YEARS, 2'b00};
    localparam logic [7:0] ADDR_RECSEL = {IDX_RECSEL, 2'b00};
    localparam logic [7:0] ADDR_CTRL = {IDX_CTRL, 2'b00};
    localparam logic [7:0] ADDR_FLAGS = {IDX_FLAGS, 2'b00};
    localparam logic [7:0] ADDR_WDOG = 8'h40;
    localparam logic [7:0] ADDR_ENABLES = 8'h44;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h48;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h4c;
    localparam logic [7:0] ADDR_SYS = 8'h50;
    // bit positions
    localparam int BIT_CENT_EN = 7;
    localparam int BIT_CENT_IND = 6;
    localparam int BIT_RECSEL = 7;
    localparam int BIT_OUT = 7;
    localparam int BIT_FT = 6;
    localparam int BIT_BATLOW = 4;
    localparam int BIT_STOP = 7;
    localparam int BIT_HALT = 6;
    localparam int BIT_AFE = 4;
    localparam int BIT_ABE = 5;
    localparam int BIT_SQUARE_WAVE_ENABLE = 3;
    localparam int BIT_WDS = 7;
    // interrupt status bits
    localparam int IRQ_BATLOW = 0;
    localparam int IRQ_CENTURY = 1;
    localparam int IRQ_RECDONE = 2;
    localparam int IRQ_W = 3;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    // timing figures and clock rate
    localparam longint CLK_HZ = 40000000;
    localparam longint TREC_SLOW_MIN_MS = 96;
    localparam longint TREC_DEF_MIN_MS = 40;
    localparam longint TREC_FAST_MIN_US = 50;
    localparam longint FT_HZ = 512;
    localparam longint BAT_CHECK_H = 24;
    localparam longint TREC_SLOW_CYC = (CLK_HZ * TREC_SLOW_MIN_MS + 999) / 1000;
    localparam longint TREC_DEF_CYC = (CLK_HZ * TREC_DEF_MIN_MS + 999) / 1000;
    localparam longint TREC_FAST_CYC =
        (CLK_HZ * TREC_FAST_MIN_US + 999999) / 1000000;
    localparam longint FT_HALF_CYC = CLK_HZ / (FT_HZ * 2);
    localparam longint BAT_CHECK_CYC = CLK_HZ * 3600 * BAT_CHECK_H;
    // recovery state machine
    typedef enum logic [1:0] {
        RTCAUX_ST_RUN = 2'b00,
        RTCAUX_ST_FAIL = 2'b01,
        RTCAUX_ST_REC = 2'b10
    } rtcaux_state_e;
    // supply-side events delivered together
    typedef struct packed {
        logic power_good;
        logic battery_low;
        logic century_roll;
    } rtcaux_sense_s;
endpackage

/* File: src/rtcaux_sync.sv */
// two-flop synchroniser for one asynchronous level
`timescale 1ns/10ps
module rtcaux_sync
    import rtcaux_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // level in and synchronised level out
    input wire logic d,
    output logic q
);
    logic s1_r; // first stage, read only by the second
    // two flops in series
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_r <= 1'b0;
            q <= 1'b0;
        end else begin
            s1_r <= d;
            q <= s1_r;
        end
    end
endmodule

/* File: src/rtcaux_timer.sv */
// down counter: load a count, pulse done when it reaches zero
`timescale 1ns/10ps
module rtcaux_timer
    import rtcaux_pkg::*;
#(
    parameter int W = 32
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // control
    input wire logic load,
    input wire logic [W-1:0] count,
    input wire logic run,
    // status
    output logic busy,
    output logic done
);
    logic [W-1:0] cnt_r; // remaining cycles
    // load wins over counting; done pulses in the cycle the count reaches zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_r <= '0;
            done <= 1'b0;
        end else if (load) begin
            cnt_r <= count;
            done <= 1'b0;
        end else begin
            done <= run && (cnt_r == W'(1));
            if (run && cnt_r != '0) begin
                cnt_r <= cnt_r - W'(1);
            end
        end
    end
    assign busy = (cnt_r != '0);
endmodule

/* File: src/rtcaux_top.sv */
// rtc auxiliary control/status: century bit, output pin, battery, recovery
`timescale 1ns/10ps
module rtcaux_top
    import rtcaux_pkg::*;
#(
    parameter longint BAT_CYC = BAT_CHECK_CYC,
    parameter longint REC_SLOW = TREC_SLOW_CYC,
    parameter longint REC_DEF = TREC_DEF_CYC
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address and data
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // supply and battery sensing, asynchronous
    input wire logic power_good,
    input wire logic battery_low,
    input wire logic century_roll,
    input wire logic alarm_irq_n,
    // pins
    output logic shared_interrupt_test_pin_oe,
    output logic reset_out_n_oe,
    output logic irq
);
    // synchronised sensing
    rtcaux_sense_s sense;
    rtcaux_sync u_s0 (.aclk(aclk), .aresetn(aresetn), .d(power_good),
        .q(sense.power_good));
    rtcaux_sync u_s1 (.aclk(aclk), .aresetn(aresetn), .d(battery_low),
        .q(sense.battery_low));
    rtcaux_sync u_s2 (.aclk(aclk), .aresetn(aresetn), .d(century_roll),
        .q(sense.century_roll));
    logic alarm_n_s; // alarm request, active low
    rtcaux_sync u_s3 (.aclk(aclk), .aresetn(aresetn), .d(alarm_irq_n),
        .q(alarm_n_s));

    // register state
    logic [7:0] years_century_reg_r;
    logic [7:0] recovery_select_clock_reg_r;
    logic [7:0] control_reg_r;
    logic [7:0] flags_reg_r;
    logic [7:0] watchdog_r; // watchdog_multiplier/resolution + steering
    logic [7:0] enables_r; // stop, halt, afe, abe, square_wave_enable
    logic [IRQ_W-1:0] irq_stat_r;
    logic [IRQ_W-1:0] irq_mask_r;
    logic first_done_r; // set once the first power-up is seen
    logic roll_d_r; // previous century rollover level
    rtcaux_state_e state_r;
    rtcaux_state_e state_nxt;

    // handy field views
    wire century_toggle_enable = years_century_reg_r[BIT_CENT_EN];
    wire recovery_time_select = recovery_select_clock_reg_r[BIT_RECSEL];
    wire oscillator_stop_bit = enables_r[BIT_STOP];
    wire frequency_test_bit = control_reg_r[BIT_FT];
    wire out_level = control_reg_r[BIT_OUT];
    wire alarm_flag_enable = enables_r[BIT_AFE];
    wire watchdog_steering_bit = watchdog_r[BIT_WDS];
    wire wdog_clear = (watchdog_r == 8'h00);

    // power sequencing events
    wire power_fall = (state_r == RTCAUX_ST_RUN) && !sense.power_good;
    wire power_rise = (state_r == RTCAUX_ST_FAIL) && sense.power_good;
    wire roll_pulse = sense.century_roll && !roll_d_r;

    // recovery interval select
    wire [31:0] rec_count = recovery_time_select ? 32'(TREC_FAST_CYC) :
        (oscillator_stop_bit ? 32'(REC_DEF) : 32'(REC_SLOW));
    logic rec_busy;
    logic rec_done;
    rtcaux_timer #(.W(32)) u_rec (
        .aclk(aclk), .aresetn(aresetn),
        .load(power_rise), .count(rec_count),
        .run(state_r == RTCAUX_ST_REC),
        .busy(rec_busy), .done(rec_done));

    // 24 hour battery check timer, reloaded after each check
    logic bat_done;
    logic bat_load_r;
    rtcaux_timer #(.W(48)) u_bat (
        .aclk(aclk), .aresetn(aresetn),
        .load(bat_load_r), .count(48'(BAT_CYC)),
        .run(state_r == RTCAUX_ST_RUN),
        .busy(), .done(bat_done));
    wire bat_check = rec_done || bat_done;

    // 512 Hz divider for frequency test
    logic [15:0] ft_cnt_r;
    logic ft_tgl_r;
    wire ft_wrap = (ft_cnt_r == 16'(FT_HALF_CYC - 1));

    // state machine for power fail and recovery
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            RTCAUX_ST_RUN: if (power_fall) state_nxt = RTCAUX_ST_FAIL;
            RTCAUX_ST_FAIL: if (power_rise) state_nxt = RTCAUX_ST_REC;
            RTCAUX_ST_REC: begin
                if (!sense.power_good) state_nxt = RTCAUX_ST_FAIL;
                else if (rec_done) state_nxt = RTCAUX_ST_RUN;
            end
            default: state_nxt = RTCAUX_ST_FAIL;
        endcase
    end

    // axi write path: take address and data in either order
    logic aw_ok_r;
    logic w_ok_r;
    logic [7:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    wire wr_fire = aw_ok_r && w_ok_r && !s_axi_bvalid;
    wire wr_allowed = (state_r == RTCAUX_ST_RUN);
    wire wr_lane0 = wr_fire && wr_allowed && w_strb_r[0];
    wire wr_map = (aw_addr_r == ADDR_YEARS) || (aw_addr_r == ADDR_RECSEL) ||
        (aw_addr_r == ADDR_CTRL) || (aw_addr_r == ADDR_FLAGS) ||
        (aw_addr_r == ADDR_WDOG) || (aw_addr_r == ADDR_ENABLES) ||
        (aw_addr_r == ADDR_IRQ_STAT) || (aw_addr_r == ADDR_IRQ_MASK) ||
        (aw_addr_r == ADDR_SYS);
    wire [7:0] wb = w_data_r[7:0];
    wire wr_years = wr_lane0 && aw_addr_r == ADDR_YEARS;
    wire wr_recsel = wr_lane0 && aw_addr_r == ADDR_RECSEL;
    wire wr_ctrl = wr_lane0 && aw_addr_r == ADDR_CTRL;
    wire wr_wdog = wr_lane0 && aw_addr_r == ADDR_WDOG;
    wire wr_en = wr_lane0 && aw_addr_r == ADDR_ENABLES;
    wire wr_stat = wr_lane0 && aw_addr_r == ADDR_IRQ_STAT;
    wire wr_mask = wr_lane0 && aw_addr_r == ADDR_IRQ_MASK;

    // address/data capture and response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_ok_r <= 1'b0;
            w_ok_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ok_r <= 1'b1;
                aw_addr_r <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ok_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_ok_r <= 1'b0;
                w_ok_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_map ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    assign s_axi_awready = !aw_ok_r;
    assign s_axi_wready = !w_ok_r;

    // axi read path
    logic [31:0] rd_word;
    always_comb begin
        case ({s_axi_araddr[7:2], 2'b00})
            ADDR_YEARS: rd_word = {24'h0, years_century_reg_r};
            ADDR_RECSEL: rd_word = {24'h0, recovery_select_clock_reg_r};
            ADDR_CTRL: rd_word = {24'h0, control_reg_r};
            ADDR_FLAGS: rd_word = {24'h0, flags_reg_r};
            ADDR_WDOG: rd_word = {24'h0, watchdog_r};
            ADDR_ENABLES: rd_word = {24'h0, enables_r};
            ADDR_IRQ_STAT: rd_word = {29'h0, irq_stat_r};
            ADDR_IRQ_MASK: rd_word = {29'h0, irq_mask_r};
            ADDR_SYS: rd_word = {30'h0, state_r};
            default: rd_word = 32'hdead_beef;
        endcase
    end
    wire rd_map = (rd_word != 32'hdead_beef);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_map ? rd_word : 32'h0000_0000;
            s_axi_rresp <= rd_map ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
    assign s_axi_arready = !s_axi_rvalid;

    // control registers: bus writes and power-up defaults
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            years_century_reg_r <= 8'h00;
            recovery_select_clock_reg_r <= 8'h00;
            control_reg_r <= 8'h80;
            watchdog_r <= 8'h00;
            enables_r <= 8'hc0;
            first_done_r <= 1'b0;
        end else if (rec_done) begin
            // power-up, keep select/stop/out when battery kept us
            first_done_r <= 1'b1;
            control_reg_r[BIT_FT] <= 1'b0;
            watchdog_r <= 8'h00;
            enables_r[BIT_HALT] <= 1'b1;
            enables_r[BIT_AFE] <= 1'b0;
            enables_r[BIT_ABE] <= 1'b0;
            enables_r[BIT_SQUARE_WAVE_ENABLE] <= 1'b0;
        end else begin
            if (wr_years) years_century_reg_r <= wb;
            else if (roll_pulse && century_toggle_enable) begin
                years_century_reg_r[BIT_CENT_IND] <=
                    !years_century_reg_r[BIT_CENT_IND];
            end
            if (wr_recsel) recovery_select_clock_reg_r <= wb;
            if (wr_ctrl) control_reg_r <= wb;
            if (wr_wdog) watchdog_r <= wb;
            if (wr_en) enables_r <= wb;
        end
    end

    // battery flag, timers and century edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags_reg_r <= 8'h00;
            bat_load_r <= 1'b1;
            roll_d_r <= 1'b0;
            state_r <= RTCAUX_ST_FAIL;
        end else begin
            state_r <= state_nxt;
            roll_d_r <= sense.century_roll;
            bat_load_r <= bat_check;
            if (bat_check) begin
                flags_reg_r[BIT_BATLOW] <= sense.battery_low;
            end
        end
    end

    // sticky interrupt status; hardware set wins over write-one clear
    wire [IRQ_W-1:0] irq_set = {rec_done, roll_pulse,
        bat_check && sense.battery_low};
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_r <= '0;
            irq_mask_r <= '0;
            irq <= 1'b0;
        end else begin
            irq_stat_r <= (irq_stat_r & ~(wr_stat ? wb[IRQ_W-1:0] : '0))
                | irq_set;
            if (wr_mask) irq_mask_r <= wb[IRQ_W-1:0];
            irq <= |(irq_stat_r & irq_mask_r);
        end
    end

    // frequency test divider, runs only with the oscillator going
    always_ff @(posedge aclk) begin
        if (!aresetn || oscillator_stop_bit) begin
            ft_cnt_r <= 16'h0000;
            ft_tgl_r <= 1'b0;
        end else if (ft_wrap) begin
            ft_cnt_r <= 16'h0000;
            ft_tgl_r <= !ft_tgl_r;
        end else begin
            ft_cnt_r <= ft_cnt_r + 16'h0001;
        end
    end

    // pin source select; oe high pulls the open-drain pin low
    wire wdog_owns = !wdog_clear && !watchdog_steering_bit;
    wire ft_mode = frequency_test_bit && !alarm_flag_enable &&
        (watchdog_steering_bit || wdog_clear);
    wire plain_out = !frequency_test_bit && !alarm_flag_enable &&
        wdog_clear;
    wire pin_low = alarm_flag_enable ? !alarm_n_s :
        wdog_owns ? 1'b0 :
        ft_mode ? (!oscillator_stop_bit && !ft_tgl_r) :
        plain_out ? !out_level : 1'b0;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            shared_interrupt_test_pin_oe <= 1'b0;
            reset_out_n_oe <= 1'b1;
        end else begin
            shared_interrupt_test_pin_oe <= pin_low;
            reset_out_n_oe <= (state_nxt != RTCAUX_ST_RUN);
        end
    end

    // checks
    property p_rst_hold;
        @(posedge aclk) disable iff (!aresetn)
        (state_r != RTCAUX_ST_RUN) |-> reset_out_n_oe;
    endproperty
    a_rst_hold: assert property (p_rst_hold)
        else $error("reset released during recovery");
    property p_wr_block;
        @(posedge aclk) disable iff (!aresetn)
        (wr_fire && !wr_allowed && !rec_done) |=>
            $stable(control_reg_r) && $stable(watchdog_r);
    endproperty
    a_wr_block: assert property (p_wr_block)
        else $error("write took effect during recovery");
    property p_cent_tgl;
        @(posedge aclk) disable iff (!aresetn)
        (roll_pulse && century_toggle_enable && !wr_years && !rec_done) |=>
            years_century_reg_r[BIT_CENT_IND] !=
            $past(years_century_reg_r[BIT_CENT_IND]);
    endproperty
    a_cent_tgl: assert property (p_cent_tgl)
        else $error("century indicator did not toggle");
    property p_cent_keep;
        @(posedge aclk) disable iff (!aresetn)
        (!century_toggle_enable && !wr_years) |=>
            $stable(years_century_reg_r[BIT_CENT_IND]);
    endproperty
    a_cent_keep: assert property (p_cent_keep)
        else $error("century indicator changed while disabled");
    property p_bl_set;
        @(posedge aclk) disable iff (!aresetn)
        (bat_check && sense.battery_low) |=> flags_reg_r[BIT_BATLOW];
    endproperty
    a_bl_set: assert property (p_bl_set)
        else $error("battery flag not set");
    property p_bl_hold;
        @(posedge aclk) disable iff (!aresetn)
        !bat_check |=> $stable(flags_reg_r[BIT_BATLOW]);
    endproperty
    a_bl_hold: assert property (p_bl_hold)
        else $error("battery flag changed between checks");
    property p_out_low;
        @(posedge aclk) disable iff (!aresetn)
        (plain_out && !out_level) |=> shared_interrupt_test_pin_oe;
    endproperty
    a_out_low: assert property (p_out_low)
        else $error("pin not pulled low");
    property p_pwr_def;
        @(posedge aclk) disable iff (!aresetn)
        rec_done |=> (watchdog_r == 8'h00) && enables_r[BIT_HALT] &&
            !control_reg_r[BIT_FT];
    endproperty
    a_pwr_def: assert property (p_pwr_def)
        else $error("power-up defaults not applied");
endmodule

/* File: tb/rtcaux_host.sv */
// host-side axi4-lite master model with register access tasks
`timescale 1ns/10ps
module rtcaux_host
    import rtcaux_pkg::*;
(
    // clock
    input wire logic aclk,
    // write channels
    output logic [7:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    // read channels
    output logic [7:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    // set once a battery flag is read: stored data is then untrusted
    logic suspect = 1'b0;
    // idle bus at time zero
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
        {s_axi_wvalid, s_axi_bready, s_axi_araddr} = '0;
        {s_axi_arvalid, s_axi_rready} = '0;
    end
    // one write: address and data offered together, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        forever begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
        end
    endtask
    // one read: rready held until the data beat is seen
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        forever begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                if (a == ADDR_FLAGS && d[BIT_BATLOW]) suspect = 1'b1;
                break;
            end
        end
    endtask
endmodule

/* File: tb/rtc_aux_control_status_test.sv */
// self-checking bench of the rtc auxiliary control/status block
`timescale 1ns/10ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module rtc_aux_control_status_test
    import rtcaux_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic power_good = 1'b0;
    logic battery_low = 1'b0;
    logic century_roll = 1'b0;
    logic alarm_irq_n = 1'b1;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic shared_interrupt_test_pin_oe, reset_out_n_oe, irq;
    int checks = 0;
    int mismatches = 0;
    int cyc = 0;
    // 40 mhz clock
    always #12.5 aclk = ~aclk;
    // design with shortened recovery and battery-check counts
    rtcaux_top #(.BAT_CYC(1000), .REC_SLOW(50), .REC_DEF(40)) dut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .power_good, .battery_low,
        .century_roll, .alarm_irq_n, .shared_interrupt_test_pin_oe,
        .reset_out_n_oe, .irq
    );
    // host model on the register bus
    rtcaux_host u_host (
        .aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready
    );
    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        u_host.wr(a, d, resp);
    endtask
    // read a register and compare the bits under a mask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                          input logic [31:0] m);
        u_host.rd(a, rd_d, resp);
        `CHK(rd_d & m, e)
    endtask
    // supply returns: count cycles the reset pin stays pulled
    task automatic rec_len(output int n);
        n = 0;
        @(posedge aclk);
        power_good <= 1'b1;
        while (reset_out_n_oe !== 1'b0 && n < 3000) begin
            @(posedge aclk);
            n++;
        end
    endtask
    // cycles until the shared pin changes level
    task automatic edge_wait(output int n);
        logic p;
        p = shared_interrupt_test_pin_oe;
        n = 0;
        while (shared_interrupt_test_pin_oe === p && n < 50000) begin
            @(posedge aclk);
            n++;
        end
    endtask
    // one rising edge on the rollover line
    task automatic roll();
        @(posedge aclk);
        century_roll <= 1'b1;
        tick(4);
        century_roll <= 1'b0;
        tick(4);
    endtask
    task automatic t_boot();
        int n;
        `CHK(reset_out_n_oe, 1'b1)
        rd_chk(ADDR_RECSEL, 32'h0, 32'h80);
        rd_chk(ADDR_CTRL, 32'h80, 32'hc0);
        rd_chk(ADDR_ENABLES, 32'hc0, 32'hf8);
        rd_chk(ADDR_WDOG, 32'h0, 32'hff);
        rec_len(n);
        `CHK(n >= 40 && n <= 48, 1'b1)
        rd_chk(ADDR_SYS, 32'h0, 32'h3);
        $display("test boot done");
    endtask
    task automatic t_pin();
        wr(ADDR_ENABLES, 32'h0);
        wr(ADDR_CTRL, 32'h0);
        `CHK(resp, RESP_OKAY)
        tick(4);
        `CHK(shared_interrupt_test_pin_oe, 1'b1)
        wr(ADDR_CTRL, 32'h80);
        tick(4);
        `CHK(shared_interrupt_test_pin_oe, 1'b0)
        $display("test pin done");
    endtask
    task automatic t_century();
        wr(ADDR_IRQ_STAT, 32'hf);
        wr(ADDR_IRQ_MASK, 32'h0);
        wr(ADDR_YEARS, 32'h80);
        roll();
        rd_chk(ADDR_YEARS, 32'hc0, 32'hc0);
        `CHK(irq, 1'b0)
        roll();
        rd_chk(ADDR_YEARS, 32'h80, 32'hc0);
        wr(ADDR_YEARS, 32'h40);
        roll();
        rd_chk(ADDR_YEARS, 32'h40, 32'hc0);
        wr(ADDR_IRQ_MASK, 32'h2);
        tick(3);
        `CHK(irq, 1'b1)
        wr(ADDR_IRQ_STAT, 32'h2);
        tick(3);
        `CHK(irq, 1'b0)
        u_host.rd(8'h2c, rd_d, resp);
        `CHK(resp, RESP_SLVERR)
        `CHK(rd_d, 32'h0)
        wr(8'h2c, 32'h0);
        `CHK(resp, RESP_SLVERR)
        $display("test century done");
    endtask
    task automatic t_battery();
        int n = 0;
        wr(ADDR_IRQ_STAT, 32'h7);
        wr(ADDR_IRQ_MASK, 32'h1);
        @(posedge aclk);
        battery_low <= 1'b1;
        // wait for a check to find it: the next one is at most a period away
        while (irq !== 1'b1 && n < 1100) begin
            @(posedge aclk);
            n++;
        end
        battery_low <= 1'b0;
        `CHK(irq, 1'b1)
        rd_chk(ADDR_FLAGS, 32'h10, 32'h10);
        tick(5);
        rd_chk(ADDR_FLAGS, 32'h10, 32'h10);
        tick(1100);
        rd_chk(ADDR_FLAGS, 32'h0, 32'h10);
        $display("test battery done");
    endtask
    task automatic t_recovery();
        logic [7:0] sel [2] = '{8'h00, 8'h80};
        int len [2] = '{50, 2000};
        int n;
        for (int i = 0; i < 2; i++) begin
            wr(ADDR_RECSEL, {24'h0, sel[i]});
            wr(ADDR_ENABLES, 32'h38);
            wr(ADDR_WDOG, 32'h05);
            wr(ADDR_CTRL, 32'hc0);
            wr(ADDR_YEARS, 32'h0);
            @(posedge aclk);
            power_good <= 1'b0;
            battery_low <= i[0];
            tick(6);
            `CHK(reset_out_n_oe, 1'b1)
            wr(ADDR_YEARS, 32'h80);
            `CHK(resp, RESP_OKAY)
            rd_chk(ADDR_YEARS, 32'h0, 32'hc0);
            rec_len(n);
            `CHK(n >= len[i] && n <= len[i] + 8, 1'b1)
            rd_chk(ADDR_RECSEL, {24'h0, sel[i]}, 32'h80);
            rd_chk(ADDR_ENABLES, 32'h40, 32'hf8);
            rd_chk(ADDR_WDOG, 32'h0, 32'hff);
            rd_chk(ADDR_CTRL, 32'h80, 32'hc0);
            rd_chk(ADDR_FLAGS, {27'h0, i[0], 4'h0}, 32'h10);
        end
        `CHK(u_host.suspect, 1'b1)
        @(posedge aclk);
        battery_low <= 1'b0;
        $display("test recovery done");
    endtask
    task automatic t_freq();
        int n;
        wr(ADDR_ENABLES, 32'h0);
        wr(ADDR_CTRL, 32'h40);
        tick(4);
        edge_wait(n);
        edge_wait(n);
        `CHK(n >= FT_HALF_CYC - 2 && n <= FT_HALF_CYC + 2, 1'b1)
        $display("test frequency done");
    endtask
    // counts and verdict
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // hang guard
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 100000) begin
            mismatches++;
            end_sim();
        end
    end
    // main sequence
    initial begin
        tick(12);
        aresetn <= 1'b1;
        tick(2);
        t_boot();
        t_pin();
        t_century();
        t_battery();
        t_recovery();
        t_freq();
        end_sim();
    end
endmodule
